// ===== rtl/acc_map.vh
`ifndef ACC_MAP_VH
`define ACC_MAP_VH

// Register addresses on the special function register bus
`define ACC_ADDR_TIMING_POWER   8'hEF
`define ACC_ADDR_MODE_CHANNEL   8'hD8
`define ACC_ADDR_CALIBRATION    8'hF5
`define ACC_ADDR_RESULT_LOW     8'hF6
`define ACC_ADDR_RESULT_HIGH    8'hF7

// Reset values
`define ACC_RESET_TIMING_POWER  8'h00
`define ACC_RESET_MODE_CHANNEL  8'h00
`define ACC_RESET_CALIBRATION   8'h00

// Timing and power control fields
`define ACC_BIT_POWER_ON        7
`define ACC_BIT_EXTERNAL_REFERENCE_SELECT         6
`define ACC_FLD_DIV_HI          5
`define ACC_FLD_DIV_LO          4
`define ACC_FLD_ACQ_HI          3
`define ACC_FLD_ACQ_LO          2
`define ACC_BIT_TIMER_TRIG      1
`define ACC_BIT_EXT_TRIG        0

// Mode and channel control fields
`define ACC_BIT_DONE_FLAG       7
`define ACC_BIT_DMA_MODE        6
`define ACC_BIT_CONTINUOUS      5
`define ACC_BIT_SINGLE          4
`define ACC_FLD_CHAN_HI         3
`define ACC_FLD_CHAN_LO         0

// Calibration register busy bit
`define ACC_BIT_BUSY            7

// Divider codes and terminal counts (ratio minus one)
`define ACC_DIV_CODE_16         2'h0
`define ACC_DIV_CODE_2          2'h1
`define ACC_DIV_CODE_4          2'h2
`define ACC_DIV_CODE_8          2'h3
`define ACC_DIV_RATIO_16        4'hF
`define ACC_DIV_RATIO_2         4'h1
`define ACC_DIV_RATIO_4         4'h3
`define ACC_DIV_RATIO_8         4'h7

// Converter clocks per conversion, excluding acquisition
`define ACC_CONV_CLOCKS         5'h11

// Channel code that ends a DMA sequence
`define ACC_CHAN_DMA_STOP       4'hF

`endif

// ===== rtl/acc_clkdiv.v
`timescale 1ns/1ns
`include "acc_map.vh"

// Converter clock generator: divides the master clock by 2, 4, 8 or 16
module acc_clkdiv (
    input  wire       clock,
    input  wire       arst_n,
    input  wire       clk_en,
    input  wire       run,
    input  wire [1:0] div_sel,
    output reg        tick,
    output reg        conv_clk
);

    reg  [3:0] count;
    reg  [3:0] ratio_m1;

    // Terminal count from the divider code
    always @* begin
        case (div_sel)
            `ACC_DIV_CODE_16: ratio_m1 = `ACC_DIV_RATIO_16;
            `ACC_DIV_CODE_2:  ratio_m1 = `ACC_DIV_RATIO_2;
            `ACC_DIV_CODE_4:  ratio_m1 = `ACC_DIV_RATIO_4;
            default:          ratio_m1 = `ACC_DIV_RATIO_8;
        endcase
    end

    // Counter restarts whenever run drops, so each conversion starts on a full period
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            count    <= 4'h0;
            tick     <= 1'b0;
            conv_clk <= 1'b0;
        end else if (clk_en) begin
            if (!run) begin
                count    <= 4'h0;
                tick     <= 1'b0;
                conv_clk <= 1'b0;
            end else if (count == ratio_m1) begin
                count    <= 4'h0;
                tick     <= 1'b1;
                conv_clk <= 1'b1; // Wrap opens the high half, so divide by 2 still toggles
            end else begin
                count    <= count + 4'h1;
                tick     <= 1'b0;
                conv_clk <= (count < (ratio_m1 >> 1));
            end
        end
    end

endmodule // acc_clkdiv

// ===== rtl/acc_conv_ctrl.v
// Behaviour
// RULE1 - result word plus channel code in result high
// RULE2 - power bit powers converter up or down
// RULE3 - reference bit picks external or internal
// RULE4 - divider field divides master clock 16/2/4/8
// RULE5 - software keeps converter clock under 4.5 MHz
// RULE6 - conversion takes seventeen converter clocks
// RULE7 - acquisition lasts one, two or three clocks; here field code 3 gives four
// RULE8 - software should pick three acquisition clocks
// RULE9 - timer overflow starts conversion when enabled
// RULE10 - low pin pulse starts conversion when enabled
// RULE11 - pin pulse wider than 100 ns
// RULE12 - done flag set per conversion, DMA block
// RULE13 - vectoring clears flag, else software clears
// RULE14 - DMA bit enables capture, auto clears
// RULE15 - address strobe stops until DMA starts
// RULE16 - continuous mode restarts after each conversion
// RULE17 - single bit starts one, clears at end
// RULE18 - channel field selects input outside DMA
// RULE19 - channel codes map inputs and stop entry
// RULE20 - DMA mode takes channel from memory
// RULE21 - busy bit shows conversion in progress
// RULE22 - triggers during conversion are ignored
// RULE23 - control registers reset to zero
`timescale 1ns/1ns
`include "acc_map.vh"

module acc_conv_ctrl #(
    parameter RESULT_WIDTH = 12
) (
    input  wire                    clock,
    input  wire                    arst_n,
    input  wire                    clk_en,
    input  wire [7:0]              sfr_addr,
    input  wire                    sfr_wr,
    input  wire [7:0]              sfr_wdata,
    input  wire                    sfr_rd,
    output reg  [7:0]              sfr_rdata,
    input  wire                    int_ack,
    input  wire                    timer2_overflow,
    input  wire                    convert_start_pin_n,
    input  wire                    dma_active,
    input  wire                    dma_conv_req,
    input  wire [3:0]              dma_channel,
    input  wire                    dma_block_done,
    input  wire [RESULT_WIDTH-1:0] core_result,
    output reg                     converter_power_on,
    output reg                     external_reference_select,
    output wire                    conv_clk,
    output reg                     track_hold,
    output reg  [3:0]              sample_channel,
    output reg                     conv_busy,
    output reg                     conversion_done_flag,
    output reg                     dma_result_ready,
    output reg                     ale_enable
);

    // Sequencer states
    localparam ST_IDLE = 2'b00;
    localparam ST_ACQ  = 2'b01;
    localparam ST_CONV = 2'b10;
    localparam ST_DONE = 2'b11;

    reg  [7:0]              conv_timing_power_ctrl;
    reg  [7:0]              conv_mode_channel_ctrl;
    reg  [6:0]              conv_calibration_ctrl;
    reg  [7:0]              result_high;
    reg  [7:0]              result_low;
    reg  [1:0]              state;
    reg  [1:0]              acq_cnt;
    reg  [4:0]              conv_cnt;
    reg                     pin_meta;
    reg                     pin_sync;
    reg                     pin_prev;
    reg                     started_by_dma;
    wire                    tick;
    wire                    powered;
    wire                    dma_mode;
    wire                    single_req;
    wire                    cont_req;
    wire                    timer_req;
    wire                    pin_req;
    wire                    dma_req;
    wire                    start;
    wire                    finish;
    wire                    wr_mode;
    wire                    wr_timing;
    wire                    wr_calib;
    wire [1:0]              acq_code;
    reg  [7:0]              next_mode;

    assign powered   = conv_timing_power_ctrl[`ACC_BIT_POWER_ON];
    assign dma_mode  = conv_mode_channel_ctrl[`ACC_BIT_DMA_MODE];
    assign acq_code  = conv_timing_power_ctrl[`ACC_FLD_ACQ_HI:`ACC_FLD_ACQ_LO];
    assign wr_mode   = sfr_wr && (sfr_addr == `ACC_ADDR_MODE_CHANNEL);
    assign wr_timing = sfr_wr && (sfr_addr == `ACC_ADDR_TIMING_POWER);
    assign wr_calib  = sfr_wr && (sfr_addr == `ACC_ADDR_CALIBRATION);

    // Pin synchroniser, first stage read only by the second
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pin_meta <= 1'b1;
            pin_sync <= 1'b1;
            pin_prev <= 1'b1;
        end else if (clk_en) begin
            pin_meta <= convert_start_pin_n;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    // Trigger sources, only honoured while idle
    // RULE17 single start
    assign single_req = conv_mode_channel_ctrl[`ACC_BIT_SINGLE] && !dma_mode;
    // RULE16 continuous restart
    assign cont_req   = conv_mode_channel_ctrl[`ACC_BIT_CONTINUOUS] && !dma_mode;
    // RULE9 timer trigger
    assign timer_req  = timer2_overflow && conv_timing_power_ctrl[`ACC_BIT_TIMER_TRIG];
    // RULE10 falling pin edge
    assign pin_req    = pin_prev && !pin_sync && conv_timing_power_ctrl[`ACC_BIT_EXT_TRIG];
    // RULE19 stop entry starts nothing
    assign dma_req    = dma_mode && dma_conv_req && (dma_channel != `ACC_CHAN_DMA_STOP);

    // RULE22 requests ignored unless idle
    assign start  = powered && (state == ST_IDLE) &&
                    (single_req || cont_req || timer_req || pin_req || dma_req);
    assign finish = (state == ST_DONE);

    // Converter clock runs only during a conversion
    // RULE4 master clock divider
    acc_clkdiv u_clkdiv (
        .clock    (clock),
        .arst_n   (arst_n),
        .clk_en   (clk_en),
        .run      (powered && (state == ST_ACQ || state == ST_CONV)),
        .div_sel  (conv_timing_power_ctrl[`ACC_FLD_DIV_HI:`ACC_FLD_DIV_LO]),
        .tick     (tick),
        .conv_clk (conv_clk)
    );

    // Conversion sequencer
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state          <= ST_IDLE;
            acq_cnt        <= 2'h0;
            conv_cnt       <= 5'h00;
            sample_channel <= 4'h0;
            started_by_dma <= 1'b0;
        end else if (clk_en) begin
            if (!powered) begin
                // RULE2 power down aborts
                state    <= ST_IDLE;
                acq_cnt  <= 2'h0;
                conv_cnt <= 5'h00;
            end else begin
                case (state)
                    ST_IDLE: begin
                        acq_cnt  <= 2'h0;
                        conv_cnt <= 5'h00;
                        if (start) begin
                            state          <= ST_ACQ;
                            started_by_dma <= dma_req;
                            // RULE20 channel from memory
                            if (dma_req) begin
                                sample_channel <= dma_channel;
                            end else begin
                                // RULE18 channel from register
                                sample_channel <= conv_mode_channel_ctrl[`ACC_FLD_CHAN_HI:
                                                                         `ACC_FLD_CHAN_LO];
                            end
                        end
                    end
                    ST_ACQ: begin
                        // RULE7 acquisition clock count
                        if (tick) begin
                            if (acq_cnt == acq_code) begin
                                state <= ST_CONV;
                            end else begin
                                acq_cnt <= acq_cnt + 2'h1;
                            end
                        end
                    end
                    ST_CONV: begin
                        // RULE6 seventeen converter clocks
                        if (tick) begin
                            if (conv_cnt == `ACC_CONV_CLOCKS - 5'h01) begin
                                state <= ST_DONE;
                            end else begin
                                conv_cnt <= conv_cnt + 5'h01;
                            end
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Status and analog control outputs
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            conv_busy                 <= 1'b0;
            track_hold                <= 1'b0;
            converter_power_on        <= 1'b0;
            external_reference_select <= 1'b0;
            dma_result_ready          <= 1'b0;
            ale_enable                <= 1'b1;
        end else if (clk_en) begin
            // RULE21 busy while converting
            conv_busy                 <= powered && (start || state == ST_ACQ ||
                                                     state == ST_CONV);
            track_hold                <= powered && (start || (state == ST_ACQ &&
                                                     !(tick && acq_cnt == acq_code)));
            // RULE2 power control
            converter_power_on        <= powered;
            // RULE3 reference select
            external_reference_select <= conv_timing_power_ctrl[`ACC_BIT_EXTERNAL_REFERENCE_SELECT];
            dma_result_ready          <= finish && started_by_dma;
            // RULE15 strobe held off until DMA runs
            ale_enable                <= !dma_mode || dma_active;
        end
    end

    // Result registers, channel code in the top nibble
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            result_high <= 8'h00;
            result_low  <= 8'h00;
        end else if (clk_en && finish) begin
            // RULE1 result and channel tag
            result_high <= {sample_channel, core_result[RESULT_WIDTH-1:8]};
            result_low  <= core_result[7:0];
        end
    end

    // Mode and channel register next value
    always @* begin
        next_mode = conv_mode_channel_ctrl;
        if (wr_mode) begin
            next_mode = sfr_wdata;
        end else if (finish) begin
            // RULE17 single bit clears at end
            next_mode[`ACC_BIT_SINGLE] = 1'b0;
        end
        // RULE13 vectoring clears flag
        if (int_ack) begin
            next_mode[`ACC_BIT_DONE_FLAG] = 1'b0;
        end
        // RULE12 set wins over clear
        if ((finish && !started_by_dma) || (dma_mode && dma_block_done)) begin
            next_mode[`ACC_BIT_DONE_FLAG] = 1'b1;
        end
        // RULE14 DMA bit clears at block end
        if (dma_block_done) begin
            next_mode[`ACC_BIT_DMA_MODE] = 1'b0;
        end
    end

    // Control registers
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            // RULE23 zero at reset
            conv_timing_power_ctrl <= `ACC_RESET_TIMING_POWER;
            conv_mode_channel_ctrl <= `ACC_RESET_MODE_CHANNEL;
            conv_calibration_ctrl  <= 7'h00;
            conversion_done_flag   <= 1'b0;
        end else if (clk_en) begin
            if (wr_timing) begin
                conv_timing_power_ctrl <= sfr_wdata;
            end
            if (wr_calib) begin
                conv_calibration_ctrl <= sfr_wdata[6:0];
            end
            conv_mode_channel_ctrl <= next_mode;
            conversion_done_flag   <= next_mode[`ACC_BIT_DONE_FLAG];
        end
    end

    // Read data, unmapped addresses read zero
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sfr_rdata <= 8'h00;
        end else if (clk_en) begin
            if (!sfr_rd) begin
                sfr_rdata <= 8'h00;
            end else if (sfr_addr == `ACC_ADDR_TIMING_POWER) begin
                sfr_rdata <= conv_timing_power_ctrl;
            end else if (sfr_addr == `ACC_ADDR_MODE_CHANNEL) begin
                sfr_rdata <= conv_mode_channel_ctrl;
            end else if (sfr_addr == `ACC_ADDR_CALIBRATION) begin
                // RULE21 busy readback
                sfr_rdata <= {conv_busy, conv_calibration_ctrl};
            end else if (sfr_addr == `ACC_ADDR_RESULT_LOW) begin
                sfr_rdata <= result_low;
            end else if (sfr_addr == `ACC_ADDR_RESULT_HIGH) begin
                sfr_rdata <= result_high;
            end else begin
                sfr_rdata <= 8'h00;
            end
        end
    end

endmodule // acc_conv_ctrl

// ===== bench/acc_conv_ctrl_monitor.sv
`timescale 1ns/1ns
// Port-level checks on the conversion controller
module acc_conv_ctrl_monitor (
    input wire       clock,
    input wire       arst_n,
    input wire [7:0] sfr_addr,
    input wire       sfr_wr,
    input wire [7:0] sfr_wdata,
    input wire       sfr_rd,
    input wire [7:0] sfr_rdata,
    input wire       int_ack,
    input wire       dma_active,
    input wire       dma_block_done,
    input wire       converter_power_on,
    input wire       external_reference_select,
    input wire       track_hold,
    input wire       conv_busy,
    input wire       conversion_done_flag,
    input wire       ale_enable
);
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);

    power_write_a: assert property (
        sfr_wr && sfr_addr == 8'hEF |-> ##2 converter_power_on == $past(sfr_wdata[7], 2))
        else $error("power bit not taken from write");
    ref_write_a: assert property (
        sfr_wr && sfr_addr == 8'hEF |-> ##2 external_reference_select == $past(sfr_wdata[6], 2))
        else $error("reference bit not taken from write");
    start_powered_a: assert property (
        $rose(conv_busy) |-> converter_power_on)
        else $error("conversion started while powered down");
    busy_min_a: assert property (
        $rose(conv_busy) |-> conv_busy [*8])
        else $error("conversion ended too early");
    track_in_busy_a: assert property (
        track_hold |-> conv_busy)
        else $error("acquisition outside conversion");
    flag_at_end_a: assert property (
        $rose(conversion_done_flag) && !$past(dma_block_done) |-> $fell(conv_busy))
        else $error("done flag not tied to conversion end");
    ack_clears_a: assert property (
        int_ack && conversion_done_flag && !conv_busy && !dma_block_done
        |=> !conversion_done_flag)
        else $error("vectoring did not clear flag");
    busy_read_a: assert property (
        sfr_rd && sfr_addr == 8'hF5 |=> sfr_rdata[7] == $past(conv_busy))
        else $error("busy bit read wrong");
    ale_dma_a: assert property (
        dma_active && $past(dma_active) |-> ale_enable)
        else $error("strobe off while capture runs");
endmodule // acc_conv_ctrl_monitor

bind acc_conv_ctrl acc_conv_ctrl_monitor i_acc_conv_ctrl_monitor (
    .clock(clock), .arst_n(arst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .int_ack(int_ack),
    .dma_active(dma_active), .dma_block_done(dma_block_done),
    .converter_power_on(converter_power_on),
    .external_reference_select(external_reference_select), .track_hold(track_hold),
    .conv_busy(conv_busy), .conversion_done_flag(conversion_done_flag),
    .ale_enable(ale_enable));

// ===== bench/acc_conv_ctrl_tb.sv
`timescale 1ns/1ns
module acc_conv_ctrl_tb;
    logic        clock, arst_n, clk_en, sfr_wr, sfr_rd, dma_active;
    logic [7:0]  sfr_addr, sfr_wdata, rv;
    logic [4:0]  pv;
    logic [3:0]  dma_channel;
    logic [11:0] core_result;
    wire  [7:0]  sfr_rdata;
    wire  [3:0]  sample_channel;
    wire         converter_power_on, external_reference_select, conv_clk, track_hold;
    wire         conv_busy, conversion_done_flag, dma_result_ready, ale_enable;
    wire  [3:0]  obs = {!conv_busy, dma_result_ready, conversion_done_flag, conv_busy};
    integer      fail_count, num_checks, nb, nt, nc, i;

    acc_conv_ctrl i_acc_conv_ctrl (
        .clock(clock), .arst_n(arst_n), .clk_en(clk_en), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
        .int_ack(pv[2]), .timer2_overflow(pv[0]), .convert_start_pin_n(!pv[1]),
        .dma_active(dma_active), .dma_conv_req(pv[3]), .dma_channel(dma_channel),
        .dma_block_done(pv[4]), .core_result(core_result),
        .converter_power_on(converter_power_on),
        .external_reference_select(external_reference_select), .conv_clk(conv_clk),
        .track_hold(track_hold), .sample_channel(sample_channel), .conv_busy(conv_busy),
        .conversion_done_flag(conversion_done_flag), .dma_result_ready(dma_result_ready),
        .ale_enable(ale_enable));

    // Master clock
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task chk(input logic [11:0] g, input logic [11:0] e);
        num_checks = num_checks + 1;
        if (g !== e) begin
            fail_count = fail_count + 1;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clock);
        sfr_wr <= 1'b0;
    endtask

    task rd(input logic [7:0] a);
        @(posedge clock);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clock);
        sfr_rd <= 1'b0;
        #1;
        rv = sfr_rdata;
    endtask

    // Strobe k: timer, pin, vectoring, capture request, block end
    task pulse(input integer k, input integer w);
        @(posedge clock);
        pv[k] <= 1'b1;
        repeat (w) @(posedge clock);
        pv[k] <= 1'b0;
    endtask

    // Bounded wait, counting busy and acquisition cycles
    task waitfor(input integer k, input integer lim);
        nb = 0;
        nt = 0;
        nc = 0;
        while (obs[k] !== 1'b1 && nb + nt < 2 * lim) begin
            @(posedge clock);
            #1;
            nb = nb + (conv_busy === 1'b1);
            nc = nc + (conv_clk === 1'b1);
            nt = nt + (track_hold === 1'b1);
            lim = lim - 1;
        end
        chk(obs[k], 1'b1);
    endtask

    task t_reset;
        rd(8'hEF);
        chk(rv, 8'h00);
        rd(8'hD8);
        chk(rv, 8'h00);
        rd(8'h80);
        chk(rv, 8'h00);
        for (i = 0; i < 4; i = i + 1) begin
            wr(8'hEF, {i[1:0], 6'h0});
            @(posedge clock);
            #1;
            chk(converter_power_on, i[1]);
            chk(external_reference_select, i[0]);
        end
        $display("test reset done");
    endtask

    task conv(input logic [1:0] dv, input logic [1:0] aq, input logic [3:0] ch);
        integer n;
        n = (dv == 2'h0) ? 16 : (1 << dv);
        core_result <= {ch, ~ch, ch};
        wr(8'hEF, {2'b10, dv, aq, 2'b00});
        wr(8'hD8, {4'h1, ch});
        waitfor(1, 2000);
        chk(nb >= (aq + 18) * n - 3 && nb <= (aq + 18) * n + 3, 1'b1);
        chk(nt >= (aq + 1) * n - 2 && nt <= (aq + 1) * n + 2, 1'b1);
        chk(nc >= (aq + 18) * n / 2 - 2 && nc <= (aq + 18) * n / 2 + 2, 1'b1);
        chk(sample_channel, ch);
        rd(8'hF7);
        chk(rv, {ch, ch});
        rd(8'hF6);
        chk(rv, {~ch, ch});
        rd(8'hD8);
        chk(rv, {4'h8, ch});
        pulse(2, 1);
        #1;
        chk(conversion_done_flag, 1'b0);
    endtask

    task trig(input integer k, input logic [7:0] cfg, input logic e);
        wr(8'hEF, cfg);
        pulse(k, k + 1);
        repeat (8) @(posedge clock);
        #1;
        chk(conv_busy, e);
        if (e) begin
            rd(8'hF5);
            chk(rv[7], 1'b1);
            pulse(k, k + 1);
            waitfor(1, 1000);
            repeat (10) @(posedge clock);
            rd(8'hF5);
            chk(rv[7], 1'b0);
            wr(8'hD8, 8'h00);
            #1;
            chk(conversion_done_flag, 1'b0);
        end
        $display("test trigger %0d done", k);
    endtask

    task t_cont;
        // divide by 2, three acquisition clocks
        wr(8'hEF, 8'h98);
        wr(8'hD8, 8'h22);
        waitfor(1, 1000);
        waitfor(0, 4);
        wr(8'hD8, 8'h00);
        waitfor(3, 1000);
        repeat (5) @(posedge clock);
        #1;
        chk(conv_busy, 1'b0);
        wr(8'hD8, 8'h00);
        $display("test continuous done");
    endtask

    task t_dma;
        wr(8'hD8, 8'h40);
        @(posedge clock);
        #1;
        chk(ale_enable, 1'b0);
        @(posedge clock);
        dma_channel <= 4'h3;
        dma_active <= 1'b1;
        pulse(3, 1);
        #1;
        chk(ale_enable, 1'b1);
        waitfor(2, 1000);
        chk(sample_channel, 4'h3);
        pulse(4, 1);
        rd(8'hD8);
        chk(rv, 8'h80);
        @(posedge clock);
        dma_active <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
        chk(ale_enable, 1'b1);
        wr(8'hD8, 8'h00);
        $display("test capture done");
    endtask

    task final_report;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        arst_n = 1'b0;
        clk_en = 1'b1;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        pv = 5'h00;
        dma_active = 1'b0;
        dma_channel = 4'h0;
        core_result = 12'h000;
        fail_count = 0;
        num_checks = 0;
        repeat (5) @(posedge clock);
        arst_n <= 1'b1;
        t_reset;
        for (i = 0; i < 13; i = i + 1) begin
            conv(i[1:0], (i < 4) ? 2'h0 : 2'(i % 3), i[3:0]);
        end
        $display("test conversions done");
        trig(0, 8'h90, 1'b0);
        trig(1, 8'h90, 1'b0);
        trig(0, 8'h92, 1'b1);
        trig(1, 8'h91, 1'b1);
        t_cont;
        t_dma;
        final_report;
    end

    // Watchdog against a hang
    initial begin
        #(100 * 40000);
        fail_count = fail_count + 1;
        final_report;
    end
endmodule // acc_conv_ctrl_tb
